/* rtl/tbgp_pkg.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose : Constants and types for the three bidirectional GPIO ports
// Assumes : APB slave, 32-bit data, one register per aligned word
// Notes   : Register indices map to byte address index * 4
//////////////////////////////////////////////////////////////////////////////
package tbgp_pkg;

    localparam int unsigned NUM_PORTS  = 3;
    localparam int unsigned PORT_WIDTH = 8;
    localparam int unsigned ADDR_WIDTH = 12;
    localparam int unsigned IDX_WIDTH  = 4;

    // Port numbering inside the arrays
    localparam int unsigned PORT_A = 0;
    localparam int unsigned PORT_B = 1;
    localparam int unsigned PORT_C = 2;

    // Register indices, byte address is index times four
    localparam logic [IDX_WIDTH-1:0] IDX_PORT_A_PIN_DATA  = 4'h0;
    localparam logic [IDX_WIDTH-1:0] IDX_PORT_B_PIN_DATA  = 4'h1;
    localparam logic [IDX_WIDTH-1:0] IDX_PORT_C_PIN_DATA  = 4'h2;
    localparam logic [IDX_WIDTH-1:0] IDX_PORT_A_DIRECTION = 4'h4;
    localparam logic [IDX_WIDTH-1:0] IDX_PORT_B_DIRECTION = 4'h5;
    localparam logic [IDX_WIDTH-1:0] IDX_PORT_C_DIRECTION = 4'h6;
    localparam logic [IDX_WIDTH-1:0] IDX_PORT_B_OPTION    = 4'h8;

    // Field positions and reset values
    localparam int unsigned        OPT_PULLUP_BIT = 0;
    localparam logic [7:0]         DIR_RESET      = 8'h00;
    localparam logic               OPT_RESET      = 1'b0;
    localparam logic [31:0]        RDATA_IDLE     = 32'h0000_0000;

    // Kind of register an index selects
    typedef enum {
        TBGP_SEL_DATA,
        TBGP_SEL_DIR,
        TBGP_SEL_OPT,
        TBGP_SEL_NONE
    } tbgp_sel_e;

    typedef struct packed {
        tbgp_sel_e   kind;
        logic [1:0]  port;
    } tbgp_dec_s;

    // Drive side of one 8-bit port
    typedef struct packed {
        logic [PORT_WIDTH-1:0] level;
        logic [PORT_WIDTH-1:0] enable;
    } tbgp_drive_s;

endpackage : tbgp_pkg

/* rtl/tbgp_ports.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose : Three 8-bit bidirectional GPIO ports behind an APB slave
// Assumes : Pin inputs synchronous to clk; zero-wait APB answers
// Notes   : Data latches carry no reset, so they power up undefined
//////////////////////////////////////////////////////////////////////////////
module tbgp_ports
    import tbgp_pkg::*;
#(
    parameter int unsigned PORTS = NUM_PORTS,
    parameter int unsigned WIDTH = PORT_WIDTH
) (
    input  wire logic                           clk,
    input  wire logic                           srst,
    // APB slave
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [ADDR_WIDTH-1:0]          paddr,
    input  wire logic [31:0]                    pwdata,
    input  wire logic [3:0]                     pstrb,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    // Pins, split into sensed level and drive side
    input  wire logic [PORTS-1:0][WIDTH-1:0]    pin_in,
    output tbgp_drive_s [PORTS-1:0]             pin_drive,
    // Port B extras
    output logic      [WIDTH-1:0]               port_b_pullup_en,
    output logic      [WIDTH-1:0]               port_b_irq_level
);

    //////////////////////////////////////////////////////////////////////////
    // Address decode

    function automatic tbgp_dec_s decode(input logic [ADDR_WIDTH-1:0] addr);
        tbgp_dec_s                 d;
        logic      [IDX_WIDTH-1:0] idx;
        d   = '{kind: TBGP_SEL_NONE, port: 2'h0};
        idx = addr[IDX_WIDTH+1:2];
        if (addr[1:0] == 2'h0 && addr[ADDR_WIDTH-1:IDX_WIDTH+2] == '0) begin
            case (idx)
                IDX_PORT_A_PIN_DATA:  d = '{kind: TBGP_SEL_DATA, port: 2'h0};
                IDX_PORT_B_PIN_DATA:  d = '{kind: TBGP_SEL_DATA, port: 2'h1};
                IDX_PORT_C_PIN_DATA:  d = '{kind: TBGP_SEL_DATA, port: 2'h2};
                IDX_PORT_A_DIRECTION: d = '{kind: TBGP_SEL_DIR, port: 2'h0};
                IDX_PORT_B_DIRECTION: d = '{kind: TBGP_SEL_DIR, port: 2'h1};
                IDX_PORT_C_DIRECTION: d = '{kind: TBGP_SEL_DIR, port: 2'h2};
                IDX_PORT_B_OPTION:    d = '{kind: TBGP_SEL_OPT, port: 2'h1};
                default:              d = '{kind: TBGP_SEL_NONE, port: 2'h0};
            endcase
        end
        return d;
    endfunction

    tbgp_dec_s dec;
    logic      access;
    logic      wr_en;
    logic      wr_lane0;

    assign dec      = decode(paddr);
    assign access   = psel && penable;
    assign wr_lane0 = pstrb[0];
    assign wr_en    = access && pwrite && wr_lane0 && (dec.kind != TBGP_SEL_NONE);

    //////////////////////////////////////////////////////////////////////////
    // Per-port state

    logic [PORTS-1:0][WIDTH-1:0] latch_q;
    logic [PORTS-1:0][WIDTH-1:0] dir_q;
    logic [PORTS-1:0][WIDTH-1:0] read_view;
    logic                        pullup_opt_q;

    sequence s_wr_reg(tbgp_sel_e k, int p);
        psel && penable && pwrite && pstrb[0] && dec.kind == k && dec.port == 2'(p);
    endsequence

    sequence s_rd_reg(tbgp_sel_e k, int p);
        psel && penable && !pwrite && dec.kind == k && dec.port == 2'(p);
    endsequence

    for (genvar p = 0; p < PORTS; p++) begin : g_port
        logic sel_data;
        logic sel_dir;

        assign sel_data = wr_en && dec.kind == TBGP_SEL_DATA && dec.port == 2'(p);
        assign sel_dir  = wr_en && dec.kind == TBGP_SEL_DIR && dec.port == 2'(p);

        // No reset here on purpose: the latches keep their value across reset
        always_ff @(posedge clk) begin
            if (sel_data) begin
                latch_q[p] <= pwdata[WIDTH-1:0];
            end
        end

        always_ff @(posedge clk) begin
            if (srst) begin
                dir_q[p] <= DIR_RESET;
            end else if (sel_dir) begin
                dir_q[p] <= pwdata[WIDTH-1:0];
            end
        end

        // Bit by bit: the direction bit picks latch or sensed level
        assign read_view[p] = (dir_q[p] & latch_q[p]) | (~dir_q[p] & pin_in[p]);

        assign pin_drive[p].level  = latch_q[p];
        assign pin_drive[p].enable = dir_q[p];

        // Checks for this port
        a_drive_follows: assert property (@(posedge clk) disable iff (srst)
            (pin_drive[p].enable == dir_q[p]) &&
            ((pin_drive[p].level & dir_q[p]) == (latch_q[p] & dir_q[p])))
            else $error("Pin drive does not follow latch and direction");

        a_dir_cleared: assert property (@(posedge clk) disable iff (1'b0)
            srst |=> (pin_drive[p].enable == '0))
            else $error("Direction not cleared by reset");

        a_latch_written: assert property (@(posedge clk) disable iff (srst)
            s_wr_reg(TBGP_SEL_DATA, p) |=>
                (latch_q[p] == $past(pwdata[WIDTH-1:0])) ##1
                (latch_q[p] == $past(pwdata[WIDTH-1:0], 2) || $past(sel_data)))
            else $error("Data write did not reach the latch");

        // Only a written latch has a known value to keep across reset
        a_latch_kept: assert property (@(posedge clk) disable iff (1'b0)
            s_wr_reg(TBGP_SEL_DATA, p) ##1 (srst && !sel_data)
                |=> (latch_q[p] == $past(latch_q[p])))
            else $error("Reset disturbed a data latch");

        a_dir_written: assert property (@(posedge clk) disable iff (srst)
            s_wr_reg(TBGP_SEL_DIR, p) ##2 s_rd_reg(TBGP_SEL_DIR, p)
                |-> (prdata[WIDTH-1:0] == $past(pwdata[WIDTH-1:0], 2)))
            else $error("Direction readback differs from write");

        a_read_mix: assert property (@(posedge clk) disable iff (srst)
            s_rd_reg(TBGP_SEL_DATA, p) |->
                ((prdata[WIDTH-1:0] & ~dir_q[p]) == (pin_in[p] & ~dir_q[p])) &&
                ((prdata[WIDTH-1:0] & dir_q[p]) == (latch_q[p] & dir_q[p])))
            else $error("Data read does not mix pin and latch");
    end

    //////////////////////////////////////////////////////////////////////////
    // Port B pullup option and interrupt feed

    always_ff @(posedge clk) begin
        if (srst) begin
            pullup_opt_q <= OPT_RESET;
        end else if (wr_en && dec.kind == TBGP_SEL_OPT) begin
            pullup_opt_q <= pwdata[OPT_PULLUP_BIT];
        end
    end

    // An output pin fights its own pullup, so the pullup goes off there
    assign port_b_pullup_en = {WIDTH{pullup_opt_q}} & ~dir_q[PORT_B];

    // Raw level, so the interrupt logic sees driven outputs too
    assign port_b_irq_level = pin_in[PORT_B];

    //////////////////////////////////////////////////////////////////////////
    // APB answer: zero wait, read data valid through the access phase

    assign pready  = 1'b1;
    assign pslverr = access && (dec.kind == TBGP_SEL_NONE);

    always_comb begin
        prdata = RDATA_IDLE;
        if (psel && !pwrite) begin
            case (dec.kind)
                TBGP_SEL_DATA: prdata[WIDTH-1:0] = read_view[dec.port];
                TBGP_SEL_DIR:  prdata[WIDTH-1:0] = dir_q[dec.port];
                TBGP_SEL_OPT:  prdata[OPT_PULLUP_BIT] = pullup_opt_q;
                default:       prdata = RDATA_IDLE;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Bus sequences and block-wide checks

    a_pullup_gate: assert property (@(posedge clk) disable iff (srst)
        s_wr_reg(TBGP_SEL_DIR, PORT_B) ##1 (pullup_opt_q == 1'b1)
            |-> ((port_b_pullup_en & $past(pwdata[WIDTH-1:0])) == '0))
        else $error("Pullup still on for an output pin");

    a_irq_level: assert property (@(posedge clk) disable iff (srst)
        port_b_irq_level == pin_in[PORT_B])
        else $error("Interrupt feed differs from port B pins");

    a_unmapped_err: assert property (@(posedge clk) disable iff (srst)
        (psel && penable && dec.kind == TBGP_SEL_NONE) |-> pslverr && pready)
        else $error("Unmapped access not flagged");

    a_write_isolated: assert property (@(posedge clk) disable iff (srst)
        s_wr_reg(TBGP_SEL_DATA, PORT_A) |=>
            (dir_q[PORT_A] == $past(dir_q[PORT_A])) &&
            (latch_q[PORT_C] == $past(latch_q[PORT_C])))
        else $error("Data write leaked into another register");

    //////////////////////////////////////////////////////////////////////////
    // Bus answer checks

    sequence s_any_read;
        psel && penable && !pwrite;
    endsequence

    sequence s_bad_read;
        psel && penable && !pwrite && dec.kind == TBGP_SEL_NONE;
    endsequence

    sequence s_bad_write;
        psel && penable && pwrite && dec.kind == TBGP_SEL_NONE;
    endsequence

    sequence s_dropped_write;
        psel && penable && pwrite && !pstrb[0];
    endsequence

    // Zero wait states: the master never sees a stretched access
    a_ready_high: assert property (@(posedge clk) disable iff (srst)
        pready == 1'b1)
        else $error("Ready dropped during a transfer");

    a_rdata_idle: assert property (@(posedge clk) disable iff (srst)
        !(psel && !pwrite) |-> (prdata == RDATA_IDLE))
        else $error("Read data driven outside a read");

    a_rdata_upper: assert property (@(posedge clk) disable iff (srst)
        s_any_read |-> (prdata[31:WIDTH] == '0))
        else $error("Upper read data bits not zero");

    a_err_access_only: assert property (@(posedge clk) disable iff (srst)
        !(psel && penable) |-> !pslverr)
        else $error("Error flagged outside an access");

    a_mapped_no_err: assert property (@(posedge clk) disable iff (srst)
        (psel && penable && dec.kind != TBGP_SEL_NONE) |-> !pslverr)
        else $error("Error flagged on a mapped register");

    a_err_read_zero: assert property (@(posedge clk) disable iff (srst)
        s_bad_read |-> (prdata == RDATA_IDLE))
        else $error("Unmapped read returned data");

    // A stray write must not reach any state, or software could lose outputs
    a_bad_write_dropped: assert property (@(posedge clk) disable iff (srst)
        s_bad_write |=>
            (dir_q == $past(dir_q)) && (pullup_opt_q == $past(pullup_opt_q)))
        else $error("Unmapped write changed a register");

    a_strobe_dropped: assert property (@(posedge clk) disable iff (srst)
        s_dropped_write |=>
            (dir_q == $past(dir_q)) && (pullup_opt_q == $past(pullup_opt_q)))
        else $error("Write without lane strobe landed");

    a_read_no_side: assert property (@(posedge clk) disable iff (srst)
        s_any_read |=> (dir_q == $past(dir_q)))
        else $error("Read changed a direction register");

    a_dir_lands_a: assert property (@(posedge clk) disable iff (srst)
        s_wr_reg(TBGP_SEL_DIR, PORT_A) |=>
            (dir_q[PORT_A] == $past(pwdata[WIDTH-1:0])))
        else $error("Port A direction write lost");

    a_dir_lands_b: assert property (@(posedge clk) disable iff (srst)
        s_wr_reg(TBGP_SEL_DIR, PORT_B) |=>
            (dir_q[PORT_B] == $past(pwdata[WIDTH-1:0])))
        else $error("Port B direction write lost");

    a_dir_lands_c: assert property (@(posedge clk) disable iff (srst)
        s_wr_reg(TBGP_SEL_DIR, PORT_C) |=>
            (dir_q[PORT_C] == $past(pwdata[WIDTH-1:0])))
        else $error("Port C direction write lost");

    a_dir_read_a: assert property (@(posedge clk) disable iff (srst)
        s_rd_reg(TBGP_SEL_DIR, PORT_A) |-> (prdata[WIDTH-1:0] == dir_q[PORT_A]))
        else $error("Port A direction read wrong");

    a_dir_read_b: assert property (@(posedge clk) disable iff (srst)
        s_rd_reg(TBGP_SEL_DIR, PORT_B) |-> (prdata[WIDTH-1:0] == dir_q[PORT_B]))
        else $error("Port B direction read wrong");

    a_dir_read_c: assert property (@(posedge clk) disable iff (srst)
        s_rd_reg(TBGP_SEL_DIR, PORT_C) |-> (prdata[WIDTH-1:0] == dir_q[PORT_C]))
        else $error("Port C direction read wrong");

    a_opt_lands: assert property (@(posedge clk) disable iff (srst)
        s_wr_reg(TBGP_SEL_OPT, PORT_B) |=>
            (pullup_opt_q == $past(pwdata[OPT_PULLUP_BIT])))
        else $error("Pullup option write lost");

    a_opt_cleared: assert property (@(posedge clk) disable iff (1'b0)
        srst |=> !pullup_opt_q)
        else $error("Pullup option not cleared by reset");

    // An output pin must never also be pulled, it would draw current
    a_pullup_off_out: assert property (@(posedge clk) disable iff (srst)
        (port_b_pullup_en & dir_q[PORT_B]) == '0)
        else $error("Pullup on for an output pin");

    a_pullup_needs_opt: assert property (@(posedge clk) disable iff (srst)
        !pullup_opt_q |-> (port_b_pullup_en == '0))
        else $error("Pullup on without the option");

    a_pullup_on_input: assert property (@(posedge clk) disable iff (srst)
        pullup_opt_q |-> ((port_b_pullup_en | dir_q[PORT_B]) == '1))
        else $error("Pullup missing on an input pin");

    a_dir_quiet: assert property (@(posedge clk) disable iff (srst)
        !wr_en |=>
            (dir_q == $past(dir_q)))
        else $error("Direction changed without a write");

    a_irq_read: assert property (@(posedge clk) disable iff (srst)
        s_rd_reg(TBGP_SEL_DATA, PORT_B) |->
            ((prdata[WIDTH-1:0] & ~dir_q[PORT_B]) == (port_b_irq_level & ~dir_q[PORT_B])))
        else $error("Interrupt feed differs from read level");

    a_opt_isolated: assert property (@(posedge clk) disable iff (srst)
        s_wr_reg(TBGP_SEL_OPT, PORT_B) |=>
            (dir_q == $past(dir_q)))
        else $error("Option write changed a direction");

    a_dir_keeps_opt: assert property (@(posedge clk) disable iff (srst)
        s_wr_reg(TBGP_SEL_DIR, PORT_B) |=>
            (pullup_opt_q == $past(pullup_opt_q)))
        else $error("Direction write changed the option");

endmodule : tbgp_ports

/* verification/tbgp_board.sv */
// Purpose: Board-side model of the three ports' pins
// Assumes: Testbench chooses which pins the board drives
// Notes: A pin nobody drives or pulls shows a toggling value
////////////////////////////////////////
module tbgp_board
    import tbgp_pkg::*;
(
    input  wire logic             clk,
    input  wire tbgp_drive_s [2:0] pin_drive,
    input  wire logic [7:0]       port_b_pullup_en,
    input  wire logic [2:0][7:0]  ext_val,
    input  wire logic [2:0][7:0]  ext_en,
    output logic      [2:0][7:0]  pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Toggles so a floating pin never reads as a stable level
    logic [7:0] flt_q = 8'h5a;
    always_ff @(posedge clk) flt_q <= ~flt_q;
    always_comb begin
        for (int p = 0; p < 3; p++) begin
            for (int b = 0; b < 8; b++) begin
                if (pin_drive[p].enable[b]) pin_in[p][b] = pin_drive[p].level[b];
                else if (ext_en[p][b]) pin_in[p][b] = ext_val[p][b];
                else if (p == 1 && port_b_pullup_en[b]) pin_in[p][b] = 1'b1;
                else pin_in[p][b] = flt_q[b];
            end
        end
    end
endmodule // tbgp_board

/* verification/test_three_bidir_gpio_ports.sv */
// Purpose: Self-checking bench for the three GPIO ports
// Assumes: Zero-wait APB slave, board model on the pins
// Notes: Read results are queued at setup and checked at access
////////////////////////////////////////
module test_three_bidir_gpio_ports import tbgp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr;
    logic [2:0][7:0] pin_in, ext_val = '0, ext_en = '1;
    tbgp_drive_s [2:0] pin_drive;
    logic [7:0] pull_en, irq_lvl, lat, dir, val;
    logic [7:0] lats [3];
    logic [32:0] exp_q [$];
    logic [31:0] rnd = 32'h4e94;
    int n_fail = 0, comparisons = 0, cyc = 0;
    tbgp_ports uut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_drive(pin_drive),
        .port_b_pullup_en(pull_en), .port_b_irq_level(irq_lvl));
    tbgp_board board (.clk(clk), .pin_drive(pin_drive), .port_b_pullup_en(pull_en),
        .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
    initial forever #10 clk = ~clk;
    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Psel stays high so a following transfer may start at once
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e = 33'h0);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) exp_q.push_back(e);
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
    endtask
    task automatic idle;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    ////////////////////////////////////////
    // Ceiling far above the roughly 85 cycles the tests need
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk({pslverr, prdata}, exp_q.pop_front());
        cyc++;
        if (cyc > 5000) begin
            n_fail++;
            test_done;
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        for (int p = 0; p < 3; p++) apb(1'b0, 12'(16 + 4 * p), 32'h0, 33'h0);
        idle;
        for (int p = 0; p < 3; p++) chk({25'h0, pin_drive[p].enable}, 33'h0);
        $display("test reset state done");
        for (int p = 0; p < 3; p++) begin
            rnd = lfsr(rnd);
            {val, dir, lat} = rnd[23:0];
            ext_val[p] <= val;
            ext_en[p] <= ~dir;
            apb(1'b1, 12'(4 * p), {24'h0, lat});
            apb(1'b1, 12'(16 + 4 * p), {24'h0, dir});
            apb(1'b0, 12'(16 + 4 * p), 32'h0, {25'h0, dir});
            apb(1'b0, 12'(4 * p), 32'h0, {25'h0, (lat & dir) | (val & ~dir)});
            lat = ~lat;
            lats[p] = lat;
            apb(1'b1, 12'(4 * p), {24'h0, lat});
            apb(1'b0, 12'(4 * p), 32'h0, {25'h0, (lat & dir) | (val & ~dir)});
            idle;
            chk({17'h0, pin_drive[p]}, {17'h0, lat, dir});
        end
        $display("test data and direction done");
        apb(1'b1, 12'h008, {24'h0, lats[2]});
        psel <= 1'b0;
        penable <= 1'b0;
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        ext_en <= '0;
        @(posedge clk);
        for (int p = 0; p < 3; p++) chk({25'h0, pin_drive[p].enable}, 33'h0);
        for (int p = 0; p < 3; p++) begin
            apb(1'b1, 12'(16 + 4 * p), 32'h0000_00ff);
            apb(1'b0, 12'(4 * p), 32'h0, {25'h0, lats[p]});
        end
        $display("test reset keeps latches done");
        apb(1'b1, 12'h020, 32'h0000_0001);
        apb(1'b1, 12'h014, 32'h0000_000f);
        apb(1'b0, 12'h004, 32'h0, {25'h0, (lats[1] & 8'h0f) | 8'hf0});
        idle;
        chk({25'h0, pull_en}, {25'h0, 8'hf0});
        chk({25'h0, irq_lvl}, {25'h0, (lats[1] & 8'h0f) | 8'hf0});
        $display("test port b pullups done");
        apb(1'b0, 12'h00c, 32'h0, {1'b1, 32'h0});
        apb(1'b0, 12'h002, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 12'h00c, 32'h0);
        pstrb <= 4'h0;
        apb(1'b1, 12'h010, 32'h0);
        pstrb <= 4'hf;
        apb(1'b0, 12'h010, 32'h0, {25'h0, 8'hff});
        idle;
        $display("test bus errors done");
        test_done;
    end
endmodule // test_three_bidir_gpio_ports
